// ### rtl/rdq_pkg.sv
// Purpose: Shared constants and types for the receive done-queue writer
// Assumes: 32-bit Wishbone register window, byte addresses
// Notes: Offsets above 0x744 and the status bit layout are local choices
package rdq_pkg;
    localparam logic [11:0] OFS_BASE_LOW = 12'h730;
    localparam logic [11:0] OFS_BASE_HIGH = 12'h734;
    localparam logic [11:0] OFS_END_INDEX = 12'h738;
    localparam logic [11:0] OFS_READ_PTR = 12'h73c;
    localparam logic [11:0] OFS_WRITE_PTR = 12'h740;
    localparam logic [11:0] OFS_FLUSH_TIMER = 12'h744;
    localparam logic [11:0] OFS_MASTER_CFG = 12'h748;
    localparam logic [11:0] OFS_DMA_STATUS = 12'h74c;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h750;
    localparam logic [11:0] OFS_CFG_SELECT = 12'h754;
    localparam logic [11:0] OFS_CFG_DATA = 12'h758;
    localparam logic [11:0] OFS_QUEUES_CTRL = 12'h780;

    localparam int BIT_FIFO_ENABLE = 4;
    localparam int BIT_FIFO_FLUSH = 5;
    localparam int BIT_THRESH_LSB = 8;
    localparam int BIT_RX_DMA_ENABLE = 0;
    localparam int BIT_WRITE_FLAG = 0;
    localparam int BIT_WRITE_ERROR = 1;
    localparam int CFG_THRESH_LSB = 7;
    localparam logic [2:0] CFG_WORD_HOST = 3'h4;
    localparam logic [2:0] CFG_WORD_D1_UPPER = 3'h3;
    localparam logic [2:0] CFG_WORD_D2_UPPER = 3'h5;

    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_HIGH_WATER = 6;
    localparam int TIMER_PRESCALE = 256;
    localparam int NUM_CHANNELS = 256;

    typedef struct packed {
        logic valid_n;
        logic eof;
        logic [2:0] status;
        logic [2:0] bufcnt;
        logic [7:0] channel;
        logic [15:0] desc;
    } rdq_entry_t;

    typedef struct packed {
        logic [7:0] channel;
        logic [15:0] desc;
        logic eof;
        logic [2:0] status;
    } rdq_buf_evt_t;

    typedef struct packed {
        logic req;
        logic last;
        logic [31:0] addr;
        logic [31:0] data;
    } rdq_mwr_t;

    typedef enum logic [0:0] {
        RDQ_IDLE = 1'b0,
        RDQ_WRITE = 1'b1
    } rdq_state_t;
endpackage

// ### rtl/rdq_writer.sv
// Purpose: Posts finished receive descriptors into a circular host done queue
// Assumes: Host memory writes go through a PCI master port on the same clock
// Notes: Queue holds end_index+1 slots; one slot always stays unused
`timescale 1ns/1ps

// Overview of operation
// RULE1 - Full when read pointer one slot ahead
// RULE2 - Write address is base plus pointer
// RULE3 - Pointer advances one dword, wraps past end
// RULE4 - End register is index; end is base+index*4
// RULE5 - Post only after receive DMA enabled
// RULE6 - Overflow sets error, skips write, pointer held
// RULE7 - Write flag after 1,2,4..128 writes
// RULE8 - Status bits raise interrupt when enabled
// RULE9 - Post per channel threshold or packet end
// RULE10 - Eight dword internal done FIFO
// RULE11 - Burst mode waits for six entries
// RULE12 - Burst only as many as fit
// RULE13 - No room: error flag, no write
// RULE14 - After burst pointer advanced, flag set
// RULE15 - FIFO disabled: entries written one by one
// RULE16 - Flush bit pushes all buffered entries out
// RULE17 - 16-bit flush timer ticks every 256 clocks
// RULE18 - Each queue write reloads flush timer
// RULE19 - Host programs nonzero timer before enabling
// RULE20 - Config RAM per channel; host writes one word
// RULE21 - Timer expiry flushes waiting entries
// RULE22 - Equal pointers mean empty queue
// RULE23 - Device changes only write pointer
// RULE24 - Entry fields packed, bit 31 zero
module rdq_writer
    import rdq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HIGH_WATER = FIFO_HIGH_WATER
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic buf_valid_i,
    input wire rdq_buf_evt_t buf_evt_i,
    output logic buf_ready_o,
    output rdq_mwr_t mwr_o,
    input wire logic mwr_ack_i,
    output logic dma_irq_o
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || HIGH_WATER < 1 || HIGH_WATER > DEPTH) begin : g_chk
        $error("rdq_writer: DEPTH must be a power of two and HIGH_WATER within it");
    end

    logic [15:0] base_low;
    logic [15:0] base_high;
    logic [15:0] end_index;
    logic [15:0] read_ptr;
    logic [15:0] write_ptr;
    logic [15:0] flush_timer_count;
    logic [15:0] queues_ctrl;
    logic rx_dma_enable;
    logic [1:0] dma_status_register;
    logic [1:0] irq_enable;
    logic [10:0] cfg_select;

    logic [15:0] cfg_host [NUM_CHANNELS];
    logic [15:0] cfg_start [NUM_CHANNELS];
    logic [2:0] cfg_tcnt [NUM_CHANNELS];

    rdq_entry_t fifo_mem [DEPTH];
    logic [PW-1:0] rd_idx;
    logic [PW-1:0] wr_idx;
    logic [PW:0] fifo_count;

    rdq_state_t state;
    logic [PW:0] burst_left;
    logic [7:0] write_count;
    logic [7:0] prescale;
    logic [15:0] flush_timer;

    // Free slots; one slot is sacrificed so full and empty differ
    function automatic logic [16:0] free_slots(input logic [15:0] wp, input logic [15:0] rp,
                                               input logic [15:0] last);
        logic [16:0] size;
        logic [16:0] used;
        size = {1'b0, last} + 17'h00001;
        if (wp >= rp) begin // RULE22
            used = {1'b0, wp} - {1'b0, rp};
        end else begin
            used = {1'b0, wp} + size - {1'b0, rp};
        end
        free_slots = size - used - 17'h00001; // RULE1
    endfunction

    function automatic logic [15:0] ptr_step(input logic [15:0] wp, input logic [15:0] last);
        if (wp >= last) begin // RULE3
            ptr_step = 16'h0000;
        end else begin
            ptr_step = wp + 16'h0001;
        end
    endfunction

    logic wb_req;
    logic wb_wr;
    logic wb_lo;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign wb_lo = wb_sel_i[0] || wb_sel_i[1];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [3:0] sel,
                                            input logic [31:0] d);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    logic fifo_en;
    logic fifo_flush;
    logic [2:0] status_thresh;
    assign fifo_en = queues_ctrl[BIT_FIFO_ENABLE];
    assign fifo_flush = queues_ctrl[BIT_FIFO_FLUSH];
    assign status_thresh = queues_ctrl[BIT_THRESH_LSB+2:BIT_THRESH_LSB];

    // Descriptor intake: per-channel buffer counting
    logic take;
    logic [7:0] ch;
    logic [2:0] thr;
    logic [2:0] tcnt_next;
    logic [15:0] start_desc;
    logic post;
    rdq_entry_t new_entry;
    assign take = buf_valid_i && buf_ready_o;
    assign ch = buf_evt_i.channel;
    assign thr = cfg_host[ch][CFG_THRESH_LSB+2:CFG_THRESH_LSB];
    assign tcnt_next = cfg_tcnt[ch] + 3'h1;
    assign start_desc = (cfg_tcnt[ch] == 3'h0) ? buf_evt_i.desc : cfg_start[ch];
    assign post = buf_evt_i.eof || (thr != 3'h0 && tcnt_next >= thr); // RULE9

    always_comb begin
        new_entry.valid_n = 1'b0; // RULE24
        new_entry.eof = buf_evt_i.eof;
        new_entry.status = buf_evt_i.status;
        new_entry.bufcnt = (thr == 3'h0) ? 3'h0 : tcnt_next;
        new_entry.channel = ch;
        new_entry.desc = start_desc;
    end

    logic [16:0] room;
    logic trigger;
    logic [PW:0] burst_n;
    logic pop_ok;
    logic drop;
    logic pop;
    logic push;
    assign room = free_slots(write_ptr, read_ptr, end_index);
    always_comb begin
        if (fifo_en) begin
            trigger = fifo_count >= (PW+1)'(HIGH_WATER) || fifo_flush // RULE11 RULE16
                || flush_timer == 16'h0000; // RULE21
        end else begin
            trigger = 1'b1; // RULE15
        end
        trigger = trigger && fifo_count != '0 && rx_dma_enable && state == RDQ_IDLE; // RULE5
        if (!fifo_en) begin
            burst_n = (PW+1)'(1);
        end else if (room < 17'(fifo_count)) begin
            burst_n = (PW+1)'(room); // RULE12
        end else begin
            burst_n = fifo_count;
        end
    end
    assign drop = trigger && room == 17'h00000; // RULE6 RULE13
    assign pop_ok = state == RDQ_WRITE && mwr_ack_i;
    assign pop = pop_ok || drop;
    assign push = take && post;

    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_mem[wr_idx] <= new_entry; // RULE10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_idx <= '0;
            wr_idx <= '0;
            fifo_count <= '0;
            buf_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wr_idx <= wr_idx + PW'(1);
            end
            if (pop) begin
                rd_idx <= rd_idx + PW'(1);
            end
            fifo_count <= fifo_count + (PW+1)'(push) - (PW+1)'(pop);
            buf_ready_o <= rx_dma_enable && (fifo_count + (PW+1)'(push) - (PW+1)'(pop)) < (PW+1)'(DEPTH);
        end
    end

    // Per-channel configuration RAM and buffer counts
    logic cfg_host_wr;
    assign cfg_host_wr = wb_wr && wb_adr_i == OFS_CFG_DATA && cfg_select[10:8] == CFG_WORD_HOST;
    always_ff @(posedge clk_i) begin
        if (cfg_host_wr) begin
            cfg_host[cfg_select[7:0]] <= merge16(cfg_host[cfg_select[7:0]], wb_sel_i, wb_dat_i); // RULE20
        end
    end
    always_ff @(posedge clk_i) begin
        // Configuring a channel restarts its buffer count; the count has no reset
        if (cfg_host_wr) begin
            cfg_tcnt[cfg_select[7:0]] <= 3'h0;
        end
        if (take) begin
            cfg_tcnt[ch] <= post ? 3'h0 : tcnt_next;
            cfg_start[ch] <= start_desc;
        end
    end

    // Host memory write sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RDQ_IDLE;
            burst_left <= '0;
            mwr_o <= '0;
        end else begin
            unique case (state)
                RDQ_IDLE: begin
                    if (trigger && !drop) begin
                        state <= RDQ_WRITE;
                        burst_left <= burst_n;
                        mwr_o.req <= 1'b1;
                        mwr_o.last <= burst_n == (PW+1)'(1);
                        mwr_o.addr <= {base_high, base_low} + {14'h0000, write_ptr, 2'b00}; // RULE2 RULE4
                        mwr_o.data <= fifo_mem[rd_idx];
                    end
                end
                RDQ_WRITE: begin
                    if (mwr_ack_i) begin
                        if (burst_left > (PW+1)'(1)) begin
                            burst_left <= burst_left - (PW+1)'(1);
                            mwr_o.last <= burst_left == (PW+1)'(2);
                            mwr_o.addr <= {base_high, base_low} + {14'h0000, ptr_step(write_ptr, end_index), 2'b00};
                            mwr_o.data <= fifo_mem[rd_idx + PW'(1)];
                        end else begin
                            state <= RDQ_IDLE;
                            burst_left <= '0;
                            mwr_o <= '0;
                        end
                    end
                end
            endcase
        end
    end

    // Flush timer: prescaled down counter, reloaded on each queue write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale <= '0;
            flush_timer <= RST_REG16;
        end else if (pop_ok) begin
            prescale <= '0;
            flush_timer <= flush_timer_count; // RULE18
        end else if (fifo_en) begin // RULE17
            prescale <= prescale + 8'h01;
            if (prescale == 8'(TIMER_PRESCALE - 1) && flush_timer != 16'h0000) begin
                flush_timer <= flush_timer - 16'h0001;
            end
        end else begin
            prescale <= '0;
            flush_timer <= flush_timer_count;
        end
    end

    // Status events
    logic status_hit;
    logic [7:0] write_count_next;
    assign write_count_next = write_count + 8'h01;
    assign status_hit = pop_ok && ({1'b0, write_count_next} >= (9'h001 << status_thresh)); // RULE7 RULE14
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_count <= '0;
        end else if (status_hit) begin
            write_count <= '0;
        end else if (pop_ok) begin
            write_count <= write_count_next;
        end
    end

    logic [1:0] status_clear;
    logic [1:0] status_set;
    assign status_clear = (wb_wr && wb_adr_i == OFS_DMA_STATUS && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'b00;
    assign status_set = {drop, status_hit};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_status_register <= 2'b00;
        end else begin
            // Set beats clear so an event in the clearing cycle survives
            dma_status_register <= (dma_status_register & ~status_clear) | status_set; // RULE6
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_irq_o <= 1'b0;
        end else begin
            dma_irq_o <= |(dma_status_register & irq_enable); // RULE8
        end
    end

    // Write pointer: hardware advance wins over a host write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_ptr <= RST_REG16;
        end else if (pop_ok) begin
            write_ptr <= ptr_step(write_ptr, end_index); // RULE3 RULE14 RULE23
        end else if (wb_wr && wb_lo && wb_adr_i == OFS_WRITE_PTR) begin
            write_ptr <= merge16(write_ptr, wb_sel_i, wb_dat_i);
        end
    end

    // Host registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_low <= RST_REG16;
            base_high <= RST_REG16;
            end_index <= RST_REG16;
            read_ptr <= RST_REG16;
            flush_timer_count <= RST_REG16; // RULE19
            queues_ctrl <= RST_REG16;
            rx_dma_enable <= 1'b0;
            irq_enable <= 2'b00;
            cfg_select <= '0;
        end else if (wb_wr && wb_lo) begin
            unique case (wb_adr_i)
                OFS_BASE_LOW: base_low <= merge16(base_low, wb_sel_i, wb_dat_i);
                OFS_BASE_HIGH: base_high <= merge16(base_high, wb_sel_i, wb_dat_i);
                OFS_END_INDEX: end_index <= merge16(end_index, wb_sel_i, wb_dat_i);
                OFS_READ_PTR: read_ptr <= merge16(read_ptr, wb_sel_i, wb_dat_i);
                OFS_FLUSH_TIMER: flush_timer_count <= merge16(flush_timer_count, wb_sel_i, wb_dat_i);
                OFS_QUEUES_CTRL: queues_ctrl <= merge16(queues_ctrl, wb_sel_i, wb_dat_i) & 16'h073d;
                OFS_MASTER_CFG: if (wb_sel_i[0]) rx_dma_enable <= wb_dat_i[BIT_RX_DMA_ENABLE];
                OFS_IRQ_ENABLE: if (wb_sel_i[0]) irq_enable <= wb_dat_i[1:0];
                OFS_CFG_SELECT: cfg_select <= 11'(merge16({5'h00, cfg_select}, wb_sel_i, wb_dat_i));
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero and still acknowledge
    logic [15:0] cfg_word;
    logic [15:0] rdat;
    always_comb begin
        unique case (cfg_select[10:8])
            CFG_WORD_D1_UPPER: cfg_word = cfg_start[cfg_select[7:0]];
            CFG_WORD_HOST: cfg_word = cfg_host[cfg_select[7:0]];
            CFG_WORD_D2_UPPER: cfg_word = {cfg_tcnt[cfg_select[7:0]], 13'h0000};
            default: cfg_word = 16'h0000;
        endcase
        unique case (wb_adr_i)
            OFS_BASE_LOW: rdat = base_low;
            OFS_BASE_HIGH: rdat = base_high;
            OFS_END_INDEX: rdat = end_index;
            OFS_READ_PTR: rdat = read_ptr;
            OFS_WRITE_PTR: rdat = write_ptr;
            OFS_FLUSH_TIMER: rdat = flush_timer_count;
            OFS_QUEUES_CTRL: rdat = queues_ctrl;
            OFS_MASTER_CFG: rdat = {15'h0000, rx_dma_enable};
            OFS_DMA_STATUS: rdat = {14'h0000, dma_status_register};
            OFS_IRQ_ENABLE: rdat = {14'h0000, irq_enable};
            OFS_CFG_SELECT: rdat = {5'h00, cfg_select};
            OFS_CFG_DATA: rdat = cfg_word;
            default: rdat = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? {16'h0000, rdat} : 32'h00000000;
        end
    end
endmodule

// ### bench/rdq_writer_checker.sv
// Purpose: Port-level assertions for the receive done-queue writer
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
module rdq_writer_checker
    import rdq_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int HIGH_WATER = FIFO_HIGH_WATER
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire rdq_mwr_t mwr_o,
    input wire logic mwr_ack_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_dword_taken;
        mwr_o.req && mwr_ack_i;
    endsequence
    sequence s_last_taken;
        s_dword_taken ##0 mwr_o.last;
    endsequence

    property p_ack_next;
        s_wb_req |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_asked;
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
    endproperty
    property p_dat_quiet;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    property p_req_hold;
        mwr_o.req && !mwr_ack_i |=> mwr_o.req && $stable(mwr_o.addr) && $stable(mwr_o.data);
    endproperty
    property p_valid_marker;
        mwr_o.req |-> !mwr_o.data[31];
    endproperty
    property p_burst_end;
        s_last_taken |=> !mwr_o.req;
    endproperty
    property p_burst_more;
        s_dword_taken ##0 !mwr_o.last |=> mwr_o.req;
    endproperty
    // Next slot is one dword on, or the queue wrapped back towards the base
    property p_step;
        s_dword_taken ##1 mwr_o.req |-> (mwr_o.addr == $past(mwr_o.addr) + 32'h4) || (mwr_o.addr < $past(mwr_o.addr));
    endproperty

    a_ack_next: assert property (p_ack_next) else $error("register request not answered next cycle");
    a_ack_pulse: assert property (p_ack_pulse) else $error("register ack longer than one cycle");
    a_ack_asked: assert property (p_ack_asked) else $error("register ack without request");
    a_dat_quiet: assert property (p_dat_quiet) else $error("read data not zero outside ack");
    a_req_hold: assert property (p_req_hold) else $error("queue write changed before ack");
    a_valid_marker: assert property (p_valid_marker) else $error("entry top bit not zero");
    a_burst_end: assert property (p_burst_end) else $error("queue write kept after last dword");
    a_burst_more: assert property (p_burst_more) else $error("burst stopped before last dword");
    a_step: assert property (p_step) else $error("queue address did not step one dword");
endmodule

bind rdq_writer rdq_writer_checker #(.DEPTH(DEPTH), .HIGH_WATER(HIGH_WATER)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mwr_o(mwr_o),
    .mwr_ack_i(mwr_ack_i)
);

// ### bench/rdq_host_mem.sv
// Purpose: Host memory behind the PCI master, acks each queue dword
// Assumes: Request held until the ack edge
// Notes: delay_i sets how many idle cycles pass before each ack
`timescale 1ns/1ps
module rdq_host_mem
    import rdq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rdq_mwr_t mwr_i,
    input wire logic [3:0] delay_i,
    output logic mwr_ack_o,
    output logic [15:0] wr_cnt_o,
    output logic [31:0] last_addr_o,
    output logic [31:0] last_data_o
);
    logic [3:0] wait_cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mwr_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            wr_cnt_o <= 16'h0000;
            last_addr_o <= 32'h0;
            last_data_o <= 32'h0;
        end else if (mwr_ack_o) begin
            // Dword lands at the edge where the writer sees the ack
            mwr_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            wr_cnt_o <= wr_cnt_o + 16'h1;
            last_addr_o <= mwr_i.addr;
            last_data_o <= mwr_i.data;
        end else if (mwr_i.req && wait_cnt >= delay_i) begin
            mwr_ack_o <= 1'b1;
        end else if (mwr_i.req) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the receive done-queue writer
// Assumes: Channel 5 posts whole packets (threshold zero)
// Notes: Host memory model answers promptly first, slowly from the burst test on
`timescale 1ns/1ps
module testbench;
    import rdq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o, buf_ready_o, mwr_ack_i, dma_irq_o;
    logic buf_valid_i = 1'b0;
    rdq_buf_evt_t buf_evt_i = '0;
    rdq_mwr_t mwr_o;
    logic [3:0] delay = 4'h0;
    logic [15:0] wr_cnt;
    logic [31:0] last_addr, last_data;
    int fails = 0;
    int samples_checked = 0;
    localparam logic [31:0] BASE = 32'h00010100;

    always #50 clk_i = ~clk_i;

    rdq_writer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .buf_valid_i(buf_valid_i), .buf_evt_i(buf_evt_i), .buf_ready_o(buf_ready_o),
        .mwr_o(mwr_o), .mwr_ack_i(mwr_ack_i), .dma_irq_o(dma_irq_o));
    rdq_host_mem u_mem (.clk_i(clk_i), .rst_i(rst_i), .mwr_i(mwr_o), .delay_i(delay), .mwr_ack_o(mwr_ack_i),
        .wr_cnt_o(wr_cnt), .last_addr_o(last_addr), .last_data_o(last_data));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1) chk("wb_ack", 32'h1, 32'h0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        wb(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask

    // Always end of packet, so every event posts one entry
    task automatic evt(input logic [15:0] d, input logic [2:0] st);
        int n;
        @(posedge clk_i);
        buf_valid_i <= 1'b1;
        buf_evt_i <= '{channel: 8'h05, desc: d, eof: 1'b1, status: st};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (buf_ready_o !== 1'b1 && n < 50);
        buf_valid_i <= 1'b0;
    endtask

    task automatic wait_writes(input int n, input int lim);
        int i;
        i = 0;
        while (wr_cnt != n && i < lim) begin
            @(posedge clk_i);
            i++;
        end
        chk("write_count", n, wr_cnt);
    endtask

    function automatic logic [31:0] ent(input logic [15:0] d, input logic [2:0] st);
        return {1'b0, 1'b1, st, 3'h0, 8'h05, d};
    endfunction

    task automatic t_reset;
        chk("ready_before_enable", 32'h0, buf_ready_o);
        rd(OFS_FLUSH_TIMER, 32'h0, "timer_reset");
        rd(OFS_QUEUES_CTRL, 32'h0, "ctrl_reset");
        wb(1'b1, 12'h7f0, 32'hffff);
        rd(12'h7f0, 32'h0, "unmapped");
        $display("test reset done");
    endtask

    task automatic t_single;
        int i;
        wb(1'b1, OFS_BASE_LOW, 32'h0100);
        wb(1'b1, OFS_BASE_HIGH, 32'h0001);
        wb(1'b1, OFS_END_INDEX, 32'h3);
        wb(1'b1, OFS_CFG_SELECT, 32'h0405);
        wb(1'b1, OFS_CFG_DATA, 32'h0);
        wb(1'b1, OFS_MASTER_CFG, 32'h1);
        for (i = 0; i < 3; i++) begin
            evt(16'h0010 + 16'(i), 3'(i));
            wait_writes(i + 1, 200);
            chk("addr", BASE + 32'(i * 4), last_addr);
            chk("entry", ent(16'h0010 + 16'(i), 3'(i)), last_data);
        end
        rd(OFS_WRITE_PTR, 32'h3, "write_ptr");
        evt(16'h0020, 3'h0);
        repeat (40) @(posedge clk_i);
        chk("full_count", 32'h3, wr_cnt);
        rd(OFS_WRITE_PTR, 32'h3, "ptr_held");
        rd(OFS_READ_PTR, 32'h0, "read_ptr");
        wb(1'b0, OFS_DMA_STATUS, 32'h0);
        chk("error_flag", 32'h1, q[1]);
        wb(1'b1, OFS_IRQ_ENABLE, 32'h2);
        repeat (3) @(posedge clk_i);
        chk("irq_on", 32'h1, dma_irq_o);
        wb(1'b1, OFS_DMA_STATUS, 32'h3);
        repeat (3) @(posedge clk_i);
        chk("irq_off", 32'h0, dma_irq_o);
        wb(1'b1, OFS_READ_PTR, 32'h2);
        evt(16'h0030, 3'h2);
        wait_writes(4, 200);
        chk("wrap_addr", BASE + 32'hc, last_addr);
        rd(OFS_WRITE_PTR, 32'h0, "wrap_ptr");
        $display("test single done");
    endtask

    task automatic t_count;
        int c, k, w;
        w = 4;
        wb(1'b1, OFS_END_INDEX, 32'hf);
        for (c = 0; c < 3; c++) begin
            wb(1'b1, OFS_QUEUES_CTRL, 32'(c << 8));
            wb(1'b1, OFS_DMA_STATUS, 32'h3);
            wb(1'b1, OFS_READ_PTR, 32'(w - 4));
            for (k = 0; k < (1 << c); k++) begin
                evt(16'h0040 + 16'(k), 3'h0);
                w++;
                wait_writes(w, 200);
                wb(1'b0, OFS_DMA_STATUS, 32'h0);
                chk("write_flag", 32'(k == (1 << c) - 1), q[0]);
            end
        end
        $display("test count done");
    endtask

    task automatic t_burst;
        int i;
        delay <= 4'h2;
        wb(1'b1, OFS_READ_PTR, 32'h7);
        wb(1'b1, OFS_FLUSH_TIMER, 32'h00ff);
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0010);
        for (i = 0; i < 5; i++) evt(16'h0050 + 16'(i), 3'h0);
        repeat (30) @(posedge clk_i);
        chk("held", 32'd11, wr_cnt);
        evt(16'h0055, 3'h1);
        wait_writes(17, 400);
        chk("burst_addr", BASE + 32'h30, last_addr);
        chk("burst_entry", ent(16'h0055, 3'h1), last_data);
        rd(OFS_WRITE_PTR, 32'hd, "burst_ptr");
        wb(1'b1, OFS_READ_PTR, 32'h1);
        for (i = 0; i < 6; i++) evt(16'h0060 + 16'(i), 3'h0);
        wait_writes(20, 400);
        repeat (30) @(posedge clk_i);
        chk("partial_count", 32'd20, wr_cnt);
        rd(OFS_WRITE_PTR, 32'h0, "partial_ptr");
        wb(1'b1, OFS_DMA_STATUS, 32'h3);
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0030);
        repeat (40) @(posedge clk_i);
        chk("no_room_count", 32'd20, wr_cnt);
        wb(1'b0, OFS_DMA_STATUS, 32'h0);
        chk("no_room_error", 32'h1, q[1]);
        rd(OFS_WRITE_PTR, 32'h0, "no_room_ptr");
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0010);
        wb(1'b1, OFS_READ_PTR, 32'h0);
        evt(16'h0070, 3'h0);
        evt(16'h0071, 3'h0);
        repeat (20) @(posedge clk_i);
        chk("flush_wait", 32'd20, wr_cnt);
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0030);
        wait_writes(22, 400);
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0010);
        $display("test burst done");
    endtask

    task automatic t_timer;
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0000);
        wb(1'b1, OFS_FLUSH_TIMER, 32'h0001);
        wb(1'b1, OFS_QUEUES_CTRL, 32'h0010);
        evt(16'h0080, 3'h0);
        wait_writes(23, 700);
        chk("timer_addr", BASE + 32'h8, last_addr);
        $display("test timer done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_single;
        t_count;
        t_burst;
        t_timer;
        tally_and_finish;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        tally_and_finish;
    end
endmodule
